// >>> src/tmfd_pkg.sv
package tmfd_pkg;
  localparam int ADDR_W = 64;
  localparam int RA_W   = 6;
  localparam int RID_W  = 24;
  localparam int PS_W   = 6;
  localparam int NREG   = 8;
  localparam int HIST_N = 8;
  // register indices
  localparam logic [RA_W-1:0] R_REGION0   = 6'h00;
  localparam logic [RA_W-1:0] R_CTRL      = 6'h08;
  localparam logic [RA_W-1:0] R_STATUS    = 6'h09;
  localparam logic [RA_W-1:0] R_SKIP      = 6'h0a;
  localparam logic [RA_W-1:0] R_FAULT     = 6'h0b;
  localparam logic [RA_W-1:0] R_HTADDR    = 6'h0c;
  localparam logic [RA_W-1:0] R_TINFO     = 6'h0d;
  localparam logic [RA_W-1:0] R_HASH      = 6'h0e;
  localparam logic [RA_W-1:0] R_HPT_BASE  = 6'h0f;
  localparam logic [RA_W-1:0] R_HIST0     = 6'h10;
  localparam logic [RA_W-1:0] R_HIST_CNT  = 6'h18;
  // region register fields
  localparam int RG_WE    = 0;
  localparam int RG_PS_LO = 2;
  localparam int RG_PS_HI = 7;
  localparam int RG_ID_LO = 8;
  localparam int RG_ID_HI = 31;
  // status fields
  localparam int ST_NI     = 0;
  localparam int ST_DATA   = 1;
  localparam int ST_VEC_LO = 2;
  localparam int ST_VEC_HI = 4;
  // skip fields
  localparam int SK_IA = 0;
  localparam int SK_DA = 1;
  // address layout
  localparam int REG_SEL_HI = 63;
  localparam int REG_SEL_LO = 61;
  localparam int ENTRY_SH   = 3;
  localparam logic [PS_W-1:0] MIN_PS     = 6'h0c;
  localparam logic [PS_W-1:0] RESET_PS   = 6'h0c;
  localparam logic [2:0]      ATTR_SWRES = 3'h1;
  localparam logic [3:0]      HIST_FULL  = 4'h8;
  typedef enum logic [2:0] {
    VEC_NONE  = 3'b000,
    VEC_ITBL  = 3'b001,
    VEC_DTBL  = 3'b010,
    VEC_IALT  = 3'b011,
    VEC_DALT  = 3'b100,
    VEC_ITLB  = 3'b101,
    VEC_DTLB  = 3'b110,
    VEC_DNEST = 3'b111
  } tmfd_vec_t;
  typedef enum logic [1:0] {
    WK_OK       = 2'b00,
    WK_ABORT    = 2'b01,
    WK_INS_FAIL = 2'b10,
    WK_TBL_MISS = 2'b11
  } tmfd_walk_t;
endpackage

// >>> src/tmfd_dispatch.sv
`timescale 1ns/1ps
// Functional notes
// - walker never recurses; its own table miss raises a hashed-table fault
// - instruction and data hashed-table faults use distinct vectors
// - hashed-table address register gets table address of faulting reference
// - table fault: translation info from table address region key and page size
// - table fault: fault address holds original program address, not table address
// - walker table references always go through the data-side buffers
// - hash register returns table address of entry mapping the given address
// - walker disabled for region raises alternate miss; enable is per region
// - alternate miss: translation info from faulting address region
// - alternate miss: fault address gets bundle or data reference address
// - collection bit 0: data TLB or alternate miss goes to the nested data vector
// - collection bit 0: fault address register is not updated
// - nested data miss leaves the interruption status register unchanged
// - collection change in flight: ordinary data miss with nested flag set
// - return with skip bit set suppresses that access-bit fault once
// - walker never inserts an entry with the reserved attribute 001
// - preferred page size is never below 4 KB
// - up to 8 translations per legacy instruction are kept for replay
// - speculative loads to non-speculative memory are deferred, never faulted
// - walker enabled: abort, insert failure or no walker gives ordinary miss
module tmfd_dispatch
  import tmfd_pkg::*;
#(
  parameter bit WALKER_PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // register port
  input  wire logic [RA_W-1:0]   reg_addr_in,
  input  wire logic [ADDR_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [ADDR_W-1:0]      reg_rdata_out,
  // walker table request
  input  wire logic              walk_req_in,
  input  wire logic [ADDR_W-1:0] walk_addr_in,
  output logic                   walk_tbl_req_out,
  output logic [ADDR_W-1:0]      walk_tbl_addr_out,
  output logic                   walk_tbl_dside_out,
  // translation miss from pipeline
  input  wire logic              miss_valid_in,
  input  wire logic              miss_data_in,
  input  wire logic [ADDR_W-1:0] miss_addr_in,
  input  wire tmfd_walk_t        miss_walk_in,
  input  wire logic [2:0]        miss_attr_in,
  input  wire logic              miss_spec_in,
  input  wire logic              miss_nonspec_mem_in,
  input  wire logic              miss_legacy_in,
  input  wire logic [ADDR_W-1:0] miss_ip_in,
  input  wire logic              purge_in,
  // access bit faults and return
  input  wire logic              abit_fault_in,
  input  wire logic              abit_data_in,
  input  wire logic              rfi_in,
  input  wire logic              insn_done_in,
  // results
  output logic                   vec_valid_out,
  output tmfd_vec_t              vec_out,
  output logic                   walk_insert_out,
  output logic                   defer_out,
  output logic                   abit_fault_out,
  output logic                   abit_data_out
);

  logic [ADDR_W-1:0] region_reg [NREG];
  logic              collection_enable_bit;
  logic              ic_inflight_reg;
  logic [ADDR_W-1:0] interruption_status_reg;
  logic [1:0]        skip_reg;
  logic [ADDR_W-1:0] fault_addr_reg;
  logic [ADDR_W-1:0] hashed_table_addr_reg;
  logic [ADDR_W-1:0] translation_info_reg;
  logic [ADDR_W-1:0] hash_src_reg;
  logic [ADDR_W-1:0] hpt_base_reg;
  logic [ADDR_W-1:0] hist_reg [HIST_N];
  logic [3:0]        hist_cnt_reg;
  logic [ADDR_W-1:0] hist_ip_reg;
  logic [1:0]        skip_arm_reg;
  logic [ADDR_W-1:0] rdata_next;
  tmfd_vec_t         vec_next;
  logic              fault_take;
  logic              walker_on;
  logic [ADDR_W-1:0] miss_tbl_addr;
  logic              wr_ctrl;
  logic              hist_same;
  logic [3:0]        hist_wptr;

  function automatic logic [PS_W-1:0] ps_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = region_reg[a[REG_SEL_HI:REG_SEL_LO]];
    return r[RG_PS_HI:RG_PS_LO];
  endfunction

  function automatic logic [ADDR_W-1:0] tinfo_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    logic [ADDR_W-1:0] t;
    r = region_reg[a[REG_SEL_HI:REG_SEL_LO]];
    t = '0;
    t[RG_ID_HI:RG_ID_LO] = r[RG_ID_HI:RG_ID_LO];
    t[RG_PS_HI:RG_PS_LO] = r[RG_PS_HI:RG_PS_LO];
    return t;
  endfunction

  // linear table: base region on top, page number scaled by entry size
  function automatic logic [ADDR_W-1:0] hash_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] vpn;
    logic [ADDR_W-1:0] h;
    vpn = {{(REG_SEL_HI-REG_SEL_LO+1){1'b0}}, a[REG_SEL_LO-1:0]} >> ps_of(a);
    h   = hpt_base_reg + (vpn << ENTRY_SH);
    h[REG_SEL_HI:REG_SEL_LO] = hpt_base_reg[REG_SEL_HI:REG_SEL_LO];
    return h;
  endfunction

  assign wr_ctrl       = reg_wr_in && (reg_addr_in == R_CTRL);
  assign walker_on     = region_reg[miss_addr_in[REG_SEL_HI:REG_SEL_LO]][RG_WE];
  assign miss_tbl_addr = hash_of(miss_addr_in);
  assign fault_take    = miss_valid_in && !(miss_spec_in && miss_nonspec_mem_in);
  assign hist_same     = (hist_cnt_reg != 4'h0) && (miss_ip_in == hist_ip_reg);
  assign hist_wptr     = hist_same ? hist_cnt_reg : 4'h0;

  // one vector per miss
  always_comb begin
    vec_next = VEC_NONE;
    if (fault_take) begin
      if (!walker_on) begin
        vec_next = miss_data_in ? VEC_DALT : VEC_IALT;
      end else if (WALKER_PRESENT && miss_walk_in == WK_TBL_MISS) begin
        vec_next = miss_data_in ? VEC_DTBL : VEC_ITBL;
      end else if (WALKER_PRESENT && miss_walk_in == WK_OK &&
                   miss_attr_in != ATTR_SWRES) begin
        vec_next = VEC_NONE;
      end else begin
        vec_next = miss_data_in ? VEC_DTLB : VEC_ITLB;
      end
      // nested path only once the cleared collection bit has settled
      if (miss_data_in && (vec_next == VEC_DTLB || vec_next == VEC_DALT) &&
          !collection_enable_bit && !ic_inflight_reg) begin
        vec_next = VEC_DNEST;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vec_valid_out   <= 1'b0;
      vec_out         <= VEC_NONE;
      walk_insert_out <= 1'b0;
      defer_out       <= 1'b0;
    end else begin
      vec_valid_out   <= vec_next != VEC_NONE;
      vec_out         <= vec_next;
      walk_insert_out <= fault_take && vec_next == VEC_NONE;
      defer_out       <= miss_valid_in && miss_spec_in && miss_nonspec_mem_in;
    end
  end

  // walker table fetches are steered to the data buffers only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      walk_tbl_req_out   <= 1'b0;
      walk_tbl_addr_out  <= '0;
      walk_tbl_dside_out <= 1'b0;
    end else begin
      walk_tbl_req_out   <= walk_req_in;
      walk_tbl_dside_out <= walk_req_in;
      if (walk_req_in) begin
        walk_tbl_addr_out <= hash_of(walk_addr_in);
      end
    end
  end

  // region registers; page size clamped to the architectural minimum
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NREG; i++) begin
        region_reg[i] <= {{(ADDR_W-RG_PS_HI-1){1'b0}}, RESET_PS, 2'b00};
      end
    end else if (reg_wr_in && reg_addr_in < R_CTRL) begin
      region_reg[reg_addr_in[2:0]] <= reg_wdata_in;
      if (reg_wdata_in[RG_PS_HI:RG_PS_LO] < MIN_PS) begin
        region_reg[reg_addr_in[2:0]][RG_PS_HI:RG_PS_LO] <= MIN_PS;
      end
    end
  end

  // collection bit; a write keeps the change in flight for one cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      collection_enable_bit <= 1'b1;
      ic_inflight_reg       <= 1'b0;
    end else begin
      ic_inflight_reg <= wr_ctrl;
      if (wr_ctrl) begin
        collection_enable_bit <= reg_wdata_in[0];
      end
    end
  end

  // interruption registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interruption_status_reg <= '0;
      fault_addr_reg          <= '0;
      hashed_table_addr_reg   <= '0;
      translation_info_reg    <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == R_FAULT) begin
        fault_addr_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == R_TINFO) begin
        translation_info_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == R_STATUS) begin
        interruption_status_reg <= reg_wdata_in;
      end
      if (vec_next != VEC_NONE) begin
        hashed_table_addr_reg <= miss_tbl_addr;
        if (collection_enable_bit && !ic_inflight_reg) begin
          fault_addr_reg <= miss_addr_in;
        end
        if (vec_next == VEC_ITBL || vec_next == VEC_DTBL) begin
          translation_info_reg <= tinfo_of(miss_tbl_addr);
        end else begin
          translation_info_reg <= tinfo_of(miss_addr_in);
        end
        if (vec_next != VEC_DNEST) begin
          interruption_status_reg <= '0;
          interruption_status_reg[ST_NI] <= ic_inflight_reg ||
                                            !collection_enable_bit;
          interruption_status_reg[ST_DATA] <= miss_data_in;
          interruption_status_reg[ST_VEC_HI:ST_VEC_LO] <= vec_next;
        end
      end
    end
  end

  // skip bits arm on return and cover one resumed instruction
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      skip_reg       <= 2'b00;
      skip_arm_reg   <= 2'b00;
      abit_fault_out <= 1'b0;
      abit_data_out  <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == R_SKIP) begin
        skip_reg <= reg_wdata_in[1:0];
      end
      if (rfi_in) begin
        skip_arm_reg <= skip_reg;
      end else if (insn_done_in) begin
        skip_arm_reg <= 2'b00;
      end
      abit_fault_out <= abit_fault_in &&
                        !(abit_data_in ? skip_arm_reg[SK_DA] : skip_arm_reg[SK_IA]);
      abit_data_out  <= abit_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hash_src_reg <= '0;
      hpt_base_reg <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == R_HASH) begin
        hash_src_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == R_HPT_BASE) begin
        hpt_base_reg <= reg_wdata_in;
      end
    end
  end

  // legacy instruction fault history: restarts when the faulting ip changes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hist_cnt_reg <= 4'h0;
      hist_ip_reg  <= '0;
    end else if (purge_in) begin
      hist_cnt_reg <= 4'h0;
    end else if (vec_next != VEC_NONE && miss_legacy_in) begin
      hist_ip_reg <= miss_ip_in;
      if (!hist_same) begin
        hist_cnt_reg <= 4'h1;
      end else if (hist_cnt_reg != HIST_FULL) begin
        hist_cnt_reg <= hist_cnt_reg + 4'h1;
      end
    end
  end

  for (genvar g = 0; g < HIST_N; g++) begin : g_hist
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        hist_reg[g] <= '0;
      end else if (!purge_in && vec_next != VEC_NONE && miss_legacy_in &&
                   hist_wptr == 4'(g)) begin
        hist_reg[g] <= miss_addr_in;
      end
    end
  end

  always_comb begin
    rdata_next = '0;
    if (reg_addr_in < R_CTRL) begin
      rdata_next = region_reg[reg_addr_in[2:0]];
    end else if (reg_addr_in >= R_HIST0 && reg_addr_in < R_HIST_CNT) begin
      rdata_next = hist_reg[reg_addr_in[2:0]];
    end else begin
      case (reg_addr_in)
        R_CTRL:     rdata_next[0] = collection_enable_bit;
        R_STATUS:   rdata_next = interruption_status_reg;
        R_SKIP:     rdata_next[1:0] = skip_reg;
        R_FAULT:    rdata_next = fault_addr_reg;
        R_HTADDR:   rdata_next = hashed_table_addr_reg;
        R_TINFO:    rdata_next = translation_info_reg;
        R_HASH:     rdata_next = hash_of(hash_src_reg);
        R_HPT_BASE: rdata_next = hpt_base_reg;
        R_HIST_CNT: rdata_next[3:0] = hist_cnt_reg;
        default:    rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_next : '0;
    end
  end

  // checks
  sequence s_tbl_miss;
    miss_valid_in && !(miss_spec_in && miss_nonspec_mem_in) && walker_on &&
    miss_walk_in == WK_TBL_MISS;
  endsequence
  // nested path reached through the alternate miss or an ordinary walker miss
  sequence s_nested;
    miss_valid_in && !(miss_spec_in && miss_nonspec_mem_in) && miss_data_in &&
    !collection_enable_bit && !ic_inflight_reg &&
    (!walker_on || miss_walk_in == WK_ABORT || miss_walk_in == WK_INS_FAIL);
  endsequence

  AST_TBL_VEC: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_tbl_miss |=> vec_valid_out && vec_out == ($past(miss_data_in) ? VEC_DTBL : VEC_ITBL))
    else $error("table miss did not raise table vector");
  AST_TBL_FADDR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_tbl_miss ##0 (collection_enable_bit && !ic_inflight_reg)
    |=> fault_addr_reg == $past(miss_addr_in))
    else $error("table fault address not the program address");
  AST_ALT_VEC: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    fault_take && !walker_on && (!miss_data_in || collection_enable_bit || ic_inflight_reg)
    |=> vec_out == ($past(miss_data_in) ? VEC_DALT : VEC_IALT))
    else $error("alternate vector missing");
  AST_NEST_VEC: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_nested |=> vec_out == VEC_DNEST)
    else $error("nested data vector missing");
  AST_NEST_ISR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_nested |=> $stable(interruption_status_reg) && $stable(fault_addr_reg))
    else $error("nested fault touched status or fault address");
  AST_INFLIGHT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    fault_take && miss_data_in && ic_inflight_reg
    |=> vec_out != VEC_DNEST && (!vec_valid_out || interruption_status_reg[ST_NI]))
    else $error("in-flight miss did not set nested flag");
  AST_ATTR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    fault_take && miss_attr_in == ATTR_SWRES |=> !walk_insert_out)
    else $error("reserved attribute entry inserted");
  AST_DEFER: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    miss_valid_in && miss_spec_in && miss_nonspec_mem_in |=> defer_out && !vec_valid_out)
    else $error("speculative load faulted");
  AST_PS_MIN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_rd_in && reg_addr_in < R_CTRL
    |=> reg_rdata_out[RG_PS_HI:RG_PS_LO] >= MIN_PS)
    else $error("page size below minimum");
  AST_DSIDE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    walk_req_in |=> walk_tbl_req_out && walk_tbl_dside_out)
    else $error("table fetch not on data side");
endmodule

// >>> testbench/tmfd_os_model.sv
`timescale 1ns/1ps
module tmfd_os_model
  import tmfd_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // vector delivered by the device
  input  wire logic       vec_valid_in,
  input  wire tmfd_vec_t  vec_in,
  // handler bookkeeping
  output logic [15:0]     taken_cnt_out,
  output tmfd_vec_t       last_vec_out
);
  // every delivered vector enters exactly one handler, so a double pulse shows in the count
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      taken_cnt_out <= 16'h0000;
      last_vec_out  <= VEC_NONE;
    end else if (vec_valid_in) begin
      taken_cnt_out <= taken_cnt_out + 16'h0001;
      last_vec_out  <= vec_in;
    end
  end
endmodule

// >>> testbench/tmfd_dispatch_test.sv
`timescale 1ns/1ps
module tmfd_dispatch_test
  import tmfd_pkg::*;
;
  localparam logic [63:0] BASE = 64'h6000_0000_0100_0000;
  localparam logic [63:0] A1   = 64'h2000_0000_0000_abc0;
  localparam logic [63:0] A2   = 64'h4000_0000_1234_5678;
  localparam logic [63:0] A3   = 64'h4000_0000_5678_0000;
  logic              clk_in              = 1'b0;
  logic              arst_n_in           = 1'b0;
  logic [RA_W-1:0]   reg_addr_in         = '0;
  logic [ADDR_W-1:0] reg_wdata_in        = '0;
  logic              reg_wr_in           = 1'b0;
  logic              reg_rd_in           = 1'b0;
  logic              walk_req_in         = 1'b0;
  logic [ADDR_W-1:0] walk_addr_in        = '0;
  logic              miss_valid_in       = 1'b0;
  logic              miss_data_in        = 1'b0;
  logic [ADDR_W-1:0] miss_addr_in        = '0;
  tmfd_walk_t        miss_walk_in        = WK_OK;
  logic [2:0]        miss_attr_in        = 3'h0;
  logic              miss_spec_in        = 1'b0;
  logic              miss_nonspec_mem_in = 1'b0;
  logic              miss_legacy_in      = 1'b0;
  logic [ADDR_W-1:0] miss_ip_in          = '0;
  logic              purge_in            = 1'b0;
  logic              abit_fault_in       = 1'b0;
  logic              abit_data_in        = 1'b0;
  logic              rfi_in              = 1'b0;
  logic              insn_done_in        = 1'b0;
  logic [ADDR_W-1:0] reg_rdata_out;
  logic              walk_tbl_req_out;
  logic [ADDR_W-1:0] walk_tbl_addr_out;
  logic              walk_tbl_dside_out;
  logic              vec_valid_out;
  tmfd_vec_t         vec_out;
  logic              walk_insert_out;
  logic              defer_out;
  logic              abit_fault_out;
  logic              abit_data_out;
  logic [15:0]       taken_cnt;
  tmfd_vec_t         last_vec;
  int                miscompares = 0;
  int                check_count = 0;
  int                cyc         = 0;

  tmfd_dispatch u_tmfd_dispatch (
    .clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .walk_req_in, .walk_addr_in, .walk_tbl_req_out,
    .walk_tbl_addr_out, .walk_tbl_dside_out, .miss_valid_in, .miss_data_in,
    .miss_addr_in, .miss_walk_in, .miss_attr_in, .miss_spec_in,
    .miss_nonspec_mem_in, .miss_legacy_in, .miss_ip_in, .purge_in,
    .abit_fault_in, .abit_data_in, .rfi_in, .insn_done_in, .vec_valid_out,
    .vec_out, .walk_insert_out, .defer_out, .abit_fault_out, .abit_data_out
  );
  tmfd_os_model u_tmfd_os_model (
    .clk_in, .arst_n_in, .vec_valid_in(vec_valid_out), .vec_in(vec_out),
    .taken_cnt_out(taken_cnt), .last_vec_out(last_vec)
  );

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input tmfd_vec_t got, input tmfd_vec_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t vec got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected table address, worked out independently of the design
  function automatic logic [63:0] hsh(input logic [63:0] a, input int ps);
    logic [63:0] t;
    t = BASE + (({3'b000, a[60:0]} >> ps) << 3);
    return {BASE[63:61], t[60:0]};
  endfunction

  // leading edge keeps two writes in a row from touching the strobe twice in one step
  task automatic wr(input logic [RA_W-1:0] a, input logic [63:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [RA_W-1:0] a, input logic [63:0] exp);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
    chk(reg_rdata_out, exp);
  endtask

  // ex is {insert, defer}; the vector is looked at only when one is expected
  task automatic miss(input logic d, input logic [63:0] a, input tmfd_walk_t w,
                      input logic [2:0] at, input tmfd_vec_t ev, input logic [1:0] ex);
    miss_valid_in <= 1'b1;
    miss_data_in  <= d;
    miss_addr_in  <= a;
    miss_walk_in  <= w;
    miss_attr_in  <= at;
    @(posedge clk_in);
    miss_valid_in <= 1'b0;
    @(posedge clk_in);
    chk({61'h0, vec_valid_out, walk_insert_out, defer_out}, {61'h0, ev != VEC_NONE, ex});
    if (ev != VEC_NONE) chk_vec(vec_out, ev);
  endtask

  task automatic abit(input logic d, input logic [1:0] ex);
    abit_fault_in <= 1'b1;
    abit_data_in  <= d;
    @(posedge clk_in);
    abit_fault_in <= 1'b0;
    @(posedge clk_in);
    chk({62'h0, abit_fault_out, abit_fault_out & abit_data_out}, {62'h0, ex});
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd_chk(R_CTRL, 64'h1);
    rd_chk(R_REGION0, 64'h30);
    wr(6'h3f, 64'hffff);
    rd_chk(6'h3f, 64'h0);
    wr(R_REGION0 + 6'h1, 64'h0012_3438);
    wr(R_REGION0 + 6'h2, 64'h0000_5535);
    wr(R_REGION0 + 6'h3, 64'h0000_7741);
    wr(R_HPT_BASE, BASE);
    wr(R_REGION0 + 6'h4, 64'h14);
    rd_chk(R_REGION0 + 6'h4, 64'h30);
    miss(1'b1, A1, WK_OK, 3'h0, VEC_DALT, 2'b00);
    rd_chk(R_FAULT, A1);
    rd_chk(R_TINFO, 64'h0012_3438);
    rd_chk(R_STATUS, 64'h12);
    miss(1'b0, A1 + 64'h40, WK_TBL_MISS, 3'h0, VEC_IALT, 2'b00);
    rd_chk(R_FAULT, A1 + 64'h40);
    miss(1'b1, A2, WK_TBL_MISS, 3'h0, VEC_DTBL, 2'b00);
    rd_chk(R_HTADDR, hsh(A2, 13));
    rd_chk(R_FAULT, A2);
    rd_chk(R_TINFO, 64'h7740);
    rd_chk(R_STATUS, 64'h0a);
    miss(1'b0, A2, WK_TBL_MISS, 3'h0, VEC_ITBL, 2'b00);
    wr(R_HASH, A2);
    rd_chk(R_HASH, hsh(A2, 13));
    miss(1'b1, A2, WK_ABORT, 3'h0, VEC_DTLB, 2'b00);
    miss(1'b0, A2, WK_INS_FAIL, 3'h0, VEC_ITLB, 2'b00);
    miss(1'b1, A2, WK_OK, ATTR_SWRES, VEC_DTLB, 2'b00);
    miss(1'b1, A2, WK_OK, 3'h0, VEC_NONE, 2'b10);
    miss_spec_in        <= 1'b1;
    miss_nonspec_mem_in <= 1'b1;
    miss(1'b1, A2, WK_ABORT, 3'h0, VEC_NONE, 2'b01);
    miss_spec_in        <= 1'b0;
    miss_nonspec_mem_in <= 1'b0;
    walk_req_in  <= 1'b1;
    walk_addr_in <= A2;
    @(posedge clk_in);
    walk_req_in <= 1'b0;
    @(posedge clk_in);
    chk({63'h0, walk_tbl_req_out & walk_tbl_dside_out}, 64'h1);
    chk(walk_tbl_addr_out, hsh(A2, 13));
    // the miss lands in the cycle right after the control write, while it is in flight
    wr(R_CTRL, 64'h0);
    miss(1'b1, A3, WK_ABORT, 3'h0, VEC_DTLB, 2'b00);
    rd_chk(R_STATUS, 64'h1b);
    miss(1'b1, A3, WK_ABORT, 3'h0, VEC_DNEST, 2'b00);
    rd_chk(R_STATUS, 64'h1b);
    rd_chk(R_FAULT, A2);
    miss(1'b0, A3, WK_ABORT, 3'h0, VEC_ITLB, 2'b00);
    rd_chk(R_FAULT, A2);
    wr(R_CTRL, 64'h1);
    abit(1'b0, 2'b10);
    wr(R_SKIP, 64'h1);
    rfi_in <= 1'b1;
    @(posedge clk_in);
    rfi_in <= 1'b0;
    abit(1'b0, 2'b00);
    abit(1'b1, 2'b11);
    insn_done_in <= 1'b1;
    @(posedge clk_in);
    insn_done_in <= 1'b0;
    abit(1'b0, 2'b10);
    miss_legacy_in <= 1'b1;
    miss_ip_in     <= 64'h100;
    repeat (9) miss(1'b1, A2, WK_ABORT, 3'h0, VEC_DTLB, 2'b00);
    rd_chk(R_HIST_CNT, 64'h8);
    rd_chk(R_HIST0 + 6'h7, A2);
    miss_ip_in <= 64'h200;
    miss(1'b1, A3, WK_ABORT, 3'h0, VEC_DTLB, 2'b00);
    rd_chk(R_HIST_CNT, 64'h1);
    rd_chk(R_HIST0, A3);
    purge_in <= 1'b1;
    @(posedge clk_in);
    purge_in <= 1'b0;
    rd_chk(R_HIST_CNT, 64'h0);
    miss_legacy_in <= 1'b0;
    chk({48'h0, taken_cnt}, 64'h14);
    chk_vec(last_vec, VEC_DTLB);
    test_done();
  end
endmodule
